// file: hw/tpa_core.sv
// Serial time-division bus to parallel bus access core
`timescale 1ns/10ps
module tpa_core
    import tpa_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic serial_bit_clock_in,
    input wire logic frame_pulse_n_in,
    input wire logic serial_in_stream_in,
    output logic serial_out_stream_a_out,
    output logic serial_out_stream_b_out,
    input wire logic mode_group_select_in,
    input wire logic submode_select_in,
    input wire logic channel_count_pin_in,
    input wire tpa_pctl_t pctl_in,
    output tpa_pctl_t pctl_out,
    output logic [2:0] pctl_oe_out,
    input wire logic [5:0] addr_in,
    output logic [5:0] addr_out,
    output logic [5:0] addr_oe_out,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_out,
    output logic status_pin_out,
    output logic status_pin_oe_out,
    output tpa_mode_t mode_out,
    output logic ch24_out
);
    localparam int SW = 23;
    // Idle pin levels: frame, data, selects high, controls released
    localparam logic [SW-1:0] SYNC_IDLE = {6'b011111, 3'b111, 14'h0000};
    logic [SW-1:0] sync_q;
    logic c4_s, f0_n_s, sti_s, mms_s, pin3_s, ccp_s;
    tpa_pctl_t pctl_s;
    logic [5:0] addr_s;
    logic [7:0] data_s;

    // All pins pass two flip-flops first
    tpa_sync #(.W(SW), .RST_VAL(SYNC_IDLE)) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in({serial_bit_clock_in, frame_pulse_n_in, serial_in_stream_in,
            mode_group_select_in, submode_select_in, channel_count_pin_in,
            pctl_in, addr_in, data_in}),
        .q_out(sync_q)
    );
    assign {c4_s, f0_n_s, sti_s, mms_s, pin3_s, ccp_s, pctl_s, addr_s, data_s} = sync_q;

    // Bit clock edges and frame alignment
    logic c4_d_r, f0_d_r, fall, rise, frame_armed_r, frame_start;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [4:0] ch, ch_next;
    logic [PHASE_W-1:0] phase;
    logic window;
    assign fall = c4_d_r && !c4_s;
    assign rise = !c4_d_r && c4_s;
    assign frame_start = fall && frame_armed_r;
    assign ch = cnt_r[8:4];
    assign ch_next = ch + 5'h01;
    assign phase = cnt_r[3:0];
    assign window = (phase == LAST_PHASE);
    assign cnt_nxt = frame_start ? '0 : cnt_r + 9'h001;

    // Channel counter: 16 bit-clock cycles per channel, 32 channels
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            c4_d_r <= 1'b0;
            f0_d_r <= 1'b1;
            frame_armed_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            c4_d_r <= c4_s;
            f0_d_r <= f0_n_s;
            // Arm on the pulse's falling edge only, so one pulse starts one frame
            if (f0_d_r && !f0_n_s) begin
                frame_armed_r <= 1'b1;
            end else if (fall) begin
                frame_armed_r <= 1'b0;
            end
            if (fall) begin
                cnt_r <= cnt_nxt;
            end
        end
    end

    // Mode and layout, latched at frame start
    tpa_mode_t mode_r, mode_dec;
    logic ch24_r;
    logic [7:0] ctrl1_r, vector_r;
    always_comb begin
        if (mms_s) begin
            mode_dec = MODE_UP;
        end else if (pin3_s) begin
            mode_dec = MODE_FAST;
        end else begin
            mode_dec = MODE_BUS;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mode_r <= MODE_UP;
            ch24_r <= 1'b0;
        end else if (frame_start) begin
            mode_r <= mode_dec;
            ch24_r <= (mode_dec == MODE_UP) ? ctrl1_r[CTRL_CH24_BIT] : !ccp_s;
        end
    end
    assign mode_out = mode_r;
    assign ch24_out = ch24_r;

    // Serial side: addresses for receive (this channel) and transmit (next channel)
    logic [4:0] map_cur, map_nxt;
    logic skip_cur, skip_nxt, ser_acc;
    assign map_cur = tpa_map(ch, ch24_r);
    assign map_nxt = tpa_map(ch_next, ch24_r);
    assign skip_cur = tpa_skip(ch, ch24_r);
    assign skip_nxt = tpa_skip(ch_next, ch24_r);
    assign ser_acc = rise && window;

    logic [7:0] rx_sh_r, tx_a_sh_r, tx_b_sh_r, tx_a_nxt_r, tx_b_nxt_r;
    logic ser_rd_d_r;
    tpa_acc_t acc_a, acc_b_rx, acc_b_tx;
    assign acc_b_rx = '{we: ser_acc && !skip_cur, addr: map_cur, data: {rx_sh_r[6:0], sti_s}};
    assign acc_b_tx = '{we: 1'b0, addr: map_nxt, data: 8'h00};

    // Memories: transmit a, transmit b, receive
    logic [7:0] a_rd [0:2];
    logic [7:0] b_rd [0:2];
    logic [1:0] a_sel;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ram
            tpa_dpram #(.AW(5), .DW(8)) u_ram (
                .clk_in(clk_in),
                .a_we_in(acc_a.we && a_sel == 2'(gi)),
                .a_addr_in(acc_a.addr),
                .a_wdata_in(acc_a.data),
                .a_rdata_out(a_rd[gi]),
                .b_we_in(gi == 2 ? acc_b_rx.we : 1'b0),
                .b_addr_in(gi == 2 ? acc_b_rx.addr : acc_b_tx.addr),
                .b_wdata_in(acc_b_rx.data),
                .b_rdata_out(b_rd[gi])
            );
        end
    endgenerate

    // Receive shift, transmit fetch and shift
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rx_sh_r <= '0;
            tx_a_sh_r <= IDLE_BYTE;
            tx_b_sh_r <= IDLE_BYTE;
            tx_a_nxt_r <= IDLE_BYTE;
            tx_b_nxt_r <= IDLE_BYTE;
            ser_rd_d_r <= 1'b0;
        end else begin
            ser_rd_d_r <= ser_acc;
            if (rise && phase[0]) begin
                rx_sh_r <= {rx_sh_r[6:0], sti_s};
            end
            if (ser_rd_d_r) begin
                tx_a_nxt_r <= skip_nxt ? IDLE_BYTE : b_rd[0];
                tx_b_nxt_r <= skip_nxt ? IDLE_BYTE : b_rd[1];
            end
            if (fall && cnt_nxt[3:0] == 4'h0) begin
                tx_a_sh_r <= tx_a_nxt_r;
                tx_b_sh_r <= tx_b_nxt_r;
            end else if (fall && !cnt_nxt[0]) begin
                tx_a_sh_r <= {tx_a_sh_r[6:0], 1'b1};
                tx_b_sh_r <= {tx_b_sh_r[6:0], 1'b1};
            end
        end
    end
    assign serial_out_stream_a_out = tx_a_sh_r[7];
    assign serial_out_stream_b_out = tx_b_sh_r[7];

    // Parallel request decode
    logic pacc, pwrite, vack, preq, conflict, c4_hi_win;
    logic [1:0] p_sel;
    logic [4:0] p_addr;
    assign pwrite = !pctl_s.rw_we;
    assign vack = (mode_r == MODE_UP) && !pin3_s && !pctl_s.strobe_n;
    assign pacc = !pctl_s.cs_n && (!pctl_s.strobe_n || (mode_r == MODE_FAST && pwrite));
    assign preq = pacc || vack;
    assign p_addr = vack ? REG_VECTOR : addr_s[4:0];
    always_comb begin
        if (vack || (mode_r == MODE_UP && addr_s[5])) begin
            p_sel = SEL_REG;
        end else if (mode_r == MODE_UP) begin
            p_sel = ctrl1_r[1:0];
        end else if (addr_s[5]) begin
            p_sel = SEL_TXB;
        end else if (pwrite) begin
            p_sel = SEL_TXA;
        end else begin
            p_sel = SEL_RX;
        end
    end
    // Same byte in the same serial window
    assign conflict = window && (((p_sel == SEL_RX) && p_addr == map_cur)
        || ((p_sel == SEL_TXA || p_sel == SEL_TXB) && p_addr == map_nxt));
    assign c4_hi_win = window && c4_s;

    // Peripheral handshake state machine
    tpa_pst_t pst_r;
    logic issue;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pst_r <= P_IDLE;
        end else if (mode_r != MODE_UP) begin
            pst_r <= P_IDLE;
        end else begin
            case (pst_r)
                P_IDLE: begin
                    if (preq) begin
                        pst_r <= conflict ? P_HOLD : P_READ;
                    end
                end
                P_HOLD: begin
                    if (!preq) begin
                        pst_r <= P_IDLE;
                    end else if (!conflict) begin
                        pst_r <= P_READ;
                    end
                end
                P_READ: begin
                    pst_r <= P_ACK;
                end
                P_ACK: begin
                    if (!preq) begin
                        pst_r <= P_IDLE;
                    end
                end
                default: begin
                    pst_r <= P_IDLE;
                end
            endcase
        end
    end
    assign issue = (mode_r == MODE_UP) && preq && !conflict
        && (pst_r == P_IDLE || pst_r == P_HOLD);

    // Fast RAM busy
    logic busy_r, pacc_d_r, m2_ok;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            busy_r <= 1'b0;
            pacc_d_r <= 1'b0;
        end else begin
            pacc_d_r <= pacc;
            if (mode_r != MODE_FAST || !window) begin
                busy_r <= 1'b0;
            end else if (pacc && conflict && ((!pacc_d_r) || c4_hi_win)) begin
                busy_r <= 1'b1;
            end
        end
    end
    assign m2_ok = (mode_r == MODE_FAST) && pacc && !busy_r && !(conflict && c4_hi_win);

    // Control registers, cleared by mode-group low pulse in peripheral mode
    always_ff @(posedge clk_in) begin
        if (rst_in || (mode_r == MODE_UP && !mms_s)) begin
            ctrl1_r <= CTRL1_RST;
            vector_r <= VECTOR_RST;
        end else if (issue && pwrite && !vack && p_sel == SEL_REG) begin
            if (p_addr == REG_CTRL1) begin
                ctrl1_r <= data_s;
            end else if (p_addr == REG_VECTOR) begin
                vector_r <= data_s;
            end
        end
    end

    // Memory port A: parallel master, or own bus cycles in controller mode
    logic m3_cap, m3_rd;
    assign m3_cap = (mode_r == MODE_BUS) && fall && phase == M3_CAPTURE_PHASE && !skip_nxt;
    assign m3_rd = (mode_r == MODE_BUS) && fall && phase == M3_RX_READ_PHASE;
    always_comb begin
        acc_a = '{we: 1'b0, addr: p_addr, data: data_s};
        a_sel = p_sel;
        if (mode_r == MODE_BUS) begin
            a_sel = phase[3] ? SEL_RX : SEL_TXA;
            acc_a.addr = phase[3] ? map_cur : map_nxt;
            acc_a.we = m3_cap;
        end else if (mode_r == MODE_UP) begin
            acc_a.we = issue && pwrite && p_sel != SEL_REG;
        end else begin
            acc_a.we = m2_ok && pwrite;
        end
    end

    // Read data capture
    logic [1:0] sel_d_r;
    logic [4:0] addr_d_r;
    logic m3_rd_d_r;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sel_d_r <= SEL_TXA;
            addr_d_r <= '0;
            m3_rd_d_r <= 1'b0;
            data_out <= '0;
        end else begin
            sel_d_r <= a_sel;
            addr_d_r <= acc_a.addr;
            m3_rd_d_r <= m3_rd;
            if (sel_d_r == SEL_REG) begin
                data_out <= (addr_d_r == REG_CTRL1) ? ctrl1_r
                    : (addr_d_r == REG_VECTOR) ? vector_r : 8'h00;
            end else if (pst_r == P_READ || m2_ok || m3_rd_d_r) begin
                data_out <= a_rd[sel_d_r];
            end
        end
    end

    // Bus controller drive and delayed select
    tpa_pctl_t pctl_r;
    logic dcs_n_r;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pctl_r <= '{cs_n: 1'b1, strobe_n: 1'b1, rw_we: 1'b1};
            dcs_n_r <= 1'b1;
            addr_out <= '0;
        end else begin
            pctl_r.cs_n <= !(mode_r == MODE_BUS);
            pctl_r.strobe_n <= !(mode_r == MODE_BUS && !phase[3]);
            pctl_r.rw_we <= !(mode_r == MODE_BUS && phase[3] && phase > M3_RX_READ_PHASE
                && phase < LAST_PHASE && !skip_cur);
            dcs_n_r <= !(mode_r == MODE_BUS && phase[3] && !skip_cur);
            addr_out <= {1'b0, acc_a.addr};
        end
    end
    assign pctl_out = pctl_r;
    assign pctl_oe_out = (mode_r == MODE_BUS) ? 3'h7 : 3'h0;
    assign addr_oe_out = (mode_r == MODE_BUS) ? 6'h3F : 6'h00;

    // Data bus enable and shared status pin
    always_comb begin
        if (mode_r == MODE_UP) begin
            data_oe_out = (pst_r == P_ACK) && !pwrite;
            status_pin_out = 1'b0;
            status_pin_oe_out = (pst_r == P_ACK);
        end else if (mode_r == MODE_FAST) begin
            data_oe_out = pacc && !pwrite && !busy_r;
            status_pin_out = 1'b0;
            status_pin_oe_out = busy_r;
        end else begin
            data_oe_out = !pctl_r.rw_we;
            status_pin_out = dcs_n_r;
            status_pin_oe_out = 1'b1;
        end
    end

    // Checks
    mode_latch_a: assert property (@(posedge clk_in) disable iff (rst_in)
        frame_start |=> mode_r == $past(mode_dec))
        else $error("mode not latched at frame start");
    mode_sub_a: assert property (@(posedge clk_in) disable iff (rst_in)
        frame_start && !mms_s |=> mode_r == ($past(pin3_s) ? MODE_FAST : MODE_BUS))
        else $error("submode decode wrong");
    layout_sel_a: assert property (@(posedge clk_in) disable iff (rst_in)
        frame_start && !mms_s |=> ch24_r == !$past(ccp_s))
        else $error("layout pin ignored");
    skip_ff_a: assert property (@(posedge clk_in) disable iff (rst_in)
        ser_rd_d_r && skip_nxt |=> tx_a_nxt_r == IDLE_BYTE && tx_b_nxt_r == IDLE_BYTE)
        else $error("skipped channel not idle");
    rx_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
        acc_b_rx.we |-> window && rise && !skip_cur)
        else $error("serial write outside slot");
    hold_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
        pst_r == P_HOLD && conflict |=> pst_r != P_READ && pst_r != P_ACK)
        else $error("parallel access not held");
    ack_seq_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(pst_r == P_ACK) |-> $past(pst_r) == P_READ && status_pin_oe_out)
        else $error("acknowledge out of order");
    busy_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
        mode_r == MODE_FAST && window && pacc && !pacc_d_r && conflict
        ##1 window |-> busy_r)
        else $error("busy missing in window");
    busy_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !window |=> !busy_r || window)
        else $error("busy outside window");
    ctl_drive_a: assert property (@(posedge clk_in) disable iff (rst_in)
        mode_r == MODE_BUS |-> addr_oe_out == 6'h3F && pctl_oe_out == 3'h7 && !busy_r)
        else $error("controller lines not driven");
    reg_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
        mode_r == MODE_UP && !mms_s |=> ctrl1_r == CTRL1_RST)
        else $error("registers not cleared");
    cov_frame_c: cover property (@(posedge clk_in) disable iff (rst_in) frame_start);
    cov_hold_c: cover property (@(posedge clk_in) disable iff (rst_in) pst_r == P_HOLD);
    cov_busy_c: cover property (@(posedge clk_in) disable iff (rst_in) $rose(busy_r));
    cov_dcs_c: cover property (@(posedge clk_in) disable iff (rst_in) $fell(dcs_n_r));
endmodule

// file: inc/tpa_pkg.sv
// Constants, types and mapping helper for the serial/parallel access core
// Functional notes
// - Mode-group select high always selects processor peripheral mode.
// - Mode-group select low: submode high gives fast RAM, low gives bus controller.
// - In peripheral mode the submode pin becomes the vector-fetch acknowledge.
// - Bus controller mode drives parallel address and control lines as outputs.
// - 32-channel layout maps memory bytes 0-31 directly to channels 0-31.
// - 24-channel layout skips every fourth channel from 0 and sends FF there.
// - Peripheral mode takes the layout from bit 5 of control register 1.
// - Fast RAM and bus controller modes take the layout from the channel-count pin.
// - Each of three serial streams has its own 32-byte dual-port memory.
// - Parallel accesses are asynchronous, serial accesses follow the bit clock.
// - Contention only when both sides hit the same byte at once.
// - Serial memory access in second half of each channel's last bit-clock cycle.
// - On contention the serial access goes first, the parallel one waits.
// - Peripheral mode delays the transfer acknowledge during contention.
// - Peripheral transfers: strobe asserted, acknowledge returned when exchange done.
// - Fast RAM contention window is the whole last bit-clock cycle of a channel.
// - Access begun before window, ended in its first half, completes normally.
// - Access running past the window's first half raises busy.
// - Access started inside the window sees busy at once; master waits.
// - Bus controller mode needs no contention handling.
// - Peripheral mode reaches all three memories and the control registers.
// - Serial streams run at 2048 kbit/s in time-division channels.
// - Low pulse on mode-group select in peripheral mode resets control registers.
// - Bus controller emits a four-bit-cell low select pulse in valid channels' last half.
package tpa_pkg;
    localparam int BIT_RATE_KBPS = 2048;
    localparam int C4_PER_BIT = 2;
    localparam int CH_PER_FRAME = 32;
    localparam int CNT_W = 9;
    localparam int PHASE_W = 4;
    localparam logic [3:0] LAST_PHASE = 4'hF;
    localparam logic [3:0] M3_CAPTURE_PHASE = 4'h7;
    localparam logic [3:0] M3_RX_READ_PHASE = 4'h8;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    localparam logic [1:0] SEL_TXA = 2'h0;
    localparam logic [1:0] SEL_TXB = 2'h1;
    localparam logic [1:0] SEL_RX = 2'h2;
    localparam logic [1:0] SEL_REG = 2'h3;
    localparam logic [4:0] REG_CTRL1 = 5'h00;
    localparam logic [4:0] REG_VECTOR = 5'h01;
    localparam int CTRL_CH24_BIT = 5;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] VECTOR_RST = 8'h0F;

    typedef enum logic [2:0] {
        MODE_UP = 3'b001,
        MODE_FAST = 3'b010,
        MODE_BUS = 3'b100
    } tpa_mode_t;

    typedef enum logic [3:0] {
        P_IDLE = 4'b0001,
        P_HOLD = 4'b0010,
        P_READ = 4'b0100,
        P_ACK = 4'b1000
    } tpa_pst_t;

    // Parallel control pins: chip select, strobe/output enable, read-write/write enable
    typedef struct packed {
        logic cs_n;
        logic strobe_n;
        logic rw_we;
    } tpa_pctl_t;

    // One memory port access
    typedef struct packed {
        logic we;
        logic [4:0] addr;
        logic [7:0] data;
    } tpa_acc_t;

    // Channel to memory byte; 24-channel layout packs three of each four channels
    function automatic logic [4:0] tpa_map(input logic [4:0] ch, input logic ch24);
        logic [4:0] g;
        g = {2'b00, ch[4:2]};
        if (ch24) begin
            return (g << 1) + g + {3'b000, ch[1:0]} - 5'h01;
        end
        return ch;
    endfunction

    function automatic logic tpa_skip(input logic [4:0] ch, input logic ch24);
        return ch24 && (ch[1:0] == 2'b00);
    endfunction
endpackage

// file: hw/tpa_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module tpa_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0 // Idle level of each pin
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second; reset to idle levels, no false edge after reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_r <= RST_VAL;
            q_out <= RST_VAL;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule

// file: hw/tpa_dpram.sv
// Dual-port byte memory with registered reads, port B wins on same-address writes
`timescale 1ns/10ps
module tpa_dpram #(
    parameter int AW = 5,
    parameter int DW = 8
) (
    input wire logic clk_in,
    input wire logic a_we_in,
    input wire logic [AW-1:0] a_addr_in,
    input wire logic [DW-1:0] a_wdata_in,
    output logic [DW-1:0] a_rdata_out,
    input wire logic b_we_in,
    input wire logic [AW-1:0] b_addr_in,
    input wire logic [DW-1:0] b_wdata_in,
    output logic [DW-1:0] b_rdata_out
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Writes; serial port B takes priority on a clash
    always_ff @(posedge clk_in) begin
        if (a_we_in && !(b_we_in && b_addr_in == a_addr_in)) begin
            mem[a_addr_in] <= a_wdata_in;
        end
        if (b_we_in) begin
            mem[b_addr_in] <= b_wdata_in;
        end
    end

    // Registered reads
    always_ff @(posedge clk_in) begin
        a_rdata_out <= mem[a_addr_in];
        b_rdata_out <= mem[b_addr_in];
    end
endmodule

// file: test/tpa_tdm_model.sv
// Serial bus partner: bit clock, frame pulse, receive pattern, transmit capture
`timescale 1ns/10ps
module tpa_tdm_model (
    output logic bclk_out,
    output logic frame_n_out,
    output logic sdi_out,
    input wire logic sdo_a_in
);
    logic [8:0] cnt;
    logic [8:0] nx;
    logic [7:0] byt;
    logic [7:0] sh;
    logic [7:0] cap_a [32];
    int frames;

    // Free-running bit clock, 200 ns period, phase unrelated to clk_in
    initial begin
        bclk_out = 1'b1;
        frame_n_out = 1'b1;
        sdi_out = 1'b1;
        cnt = 9'h1FF;
        frames = 0;
        #7;
        forever #100 bclk_out = ~bclk_out;
    end

    // Frame pulse spans the fall that opens a frame; capture tx bits late in each cell
    always @(posedge bclk_out) begin
        frame_n_out <= (cnt != 9'h1FF);
        if (cnt[0]) begin
            sh <= {sh[6:0], sdo_a_in};
        end
        if (cnt[3:0] == 4'hF) begin
            cap_a[cnt[8:4]] <= {sh[6:0], sdo_a_in};
        end
    end

    // Channel counter; send A0 plus channel number, MSB first, two cycles a bit
    always @(negedge bclk_out) begin
        nx = cnt + 9'h001;
        byt = 8'hA0 | {3'h0, nx[8:4]};
        cnt <= nx;
        sdi_out <= byt[~nx[3:1]];
        if (nx == 9'h000) begin
            frames <= frames + 1;
        end
    end
endmodule

// file: test/tpa_core_test.sv
// Testbench for the serial/parallel access core
`timescale 1ns/10ps
module tpa_core_test;
    import tpa_pkg::*;
    logic clk_in, rst_in, bclk, fp_n, sdi, sdo_a, mgs, sub, ccp;
    tpa_pctl_t pctl, pctl_out;
    logic [5:0] addr, addr_out, addr_oe;
    logic [7:0] din, data_out, got;
    logic [2:0] pctl_oe;
    logic st_oe, st, doe;
    tpa_mode_t mode;
    logic ch24;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    int k;

    tpa_core tpa_core_inst (.clk_in(clk_in), .rst_in(rst_in), .serial_bit_clock_in(bclk),
        .frame_pulse_n_in(fp_n), .serial_in_stream_in(sdi), .serial_out_stream_a_out(sdo_a),
        .serial_out_stream_b_out(), .mode_group_select_in(mgs), .submode_select_in(sub),
        .channel_count_pin_in(ccp), .pctl_in(pctl), .pctl_out(pctl_out),
        .pctl_oe_out(pctl_oe), .addr_in(addr), .addr_out(addr_out), .addr_oe_out(addr_oe),
        .data_in(din), .data_out(data_out), .data_oe_out(doe), .status_pin_out(st),
        .status_pin_oe_out(st_oe), .mode_out(mode), .ch24_out(ch24));
    tpa_tdm_model tpa_tdm_model_inst (.bclk_out(bclk), .frame_n_out(fp_n), .sdi_out(sdi),
        .sdo_a_in(sdo_a));

    // System clock and cycle ceiling
    always #12.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            errors = errors + 1;
            give_verdict();
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares = compares + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Strobe handshake: hold until acknowledge, then release and wait for its end
    task automatic acc(input logic [5:0] a, input logic rd, input logic [7:0] wd);
        int n;
        @(negedge clk_in);
        addr = a;
        din = wd;
        pctl = {2'b00, rd};
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (st_oe !== 1'b1 && n < 100);
        got = data_out;
        chk({7'h00, st_oe}, 8'h01);
        chk({7'h00, doe}, {7'h00, rd});
        pctl = 3'h7;
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (st_oe !== 1'b0 && n < 100);
    endtask

    task automatic fw(input int n);
        int s;
        s = tpa_tdm_model_inst.frames;
        wait (tpa_tdm_model_inst.frames >= s + n);
        repeat (8) @(negedge clk_in);
    endtask

    task automatic give_verdict;
        if (errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        clk_in = 1'b0;
        rst_in = 1'b1;
        mgs = 1'b1;
        sub = 1'b1;
        ccp = 1'b1;
        pctl = 3'h7;
        addr = 6'h00;
        din = 8'h00;
        repeat (3) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (3) @(negedge clk_in);
        fw(1);
        chk({5'h00, mode}, {5'h00, MODE_UP});
        acc(6'h20, 1'b1, 8'h00); chk(got, CTRL1_RST);
        acc(6'h21, 1'b1, 8'h00); chk(got, VECTOR_RST);
        acc(6'h05, 1'b0, 8'hA5);
        fw(2);
        chk(tpa_tdm_model_inst.cap_a[5], 8'hA5);
        acc(6'h20, 1'b0, 8'h02);
        acc(6'h07, 1'b1, 8'h00); chk(got, 8'hA7);
        acc(6'h20, 1'b0, 8'h20);
        fw(2);
        chk({7'h00, ch24}, 8'h01);
        chk(tpa_tdm_model_inst.cap_a[4], IDLE_BYTE);
        chk(tpa_tdm_model_inst.cap_a[7], 8'hA5);
        acc(6'h20, 1'b0, 8'h22);
        acc(6'h05, 1'b1, 8'h00); chk(got, 8'hA7);
        acc(6'h02, 1'b1, 8'h00); chk(got, 8'hA3);
        mgs = 1'b0;
        repeat (4) @(negedge clk_in);
        mgs = 1'b1;
        repeat (4) @(negedge clk_in);
        acc(6'h20, 1'b1, 8'h00); chk(got, CTRL1_RST);
        sub = 1'b0;
        fw(1);
        chk({5'h00, mode}, {5'h00, MODE_UP});
        mgs = 1'b0;
        sub = 1'b1;
        ccp = 1'b0;
        fw(1);
        chk({5'h00, mode}, {5'h00, MODE_FAST});
        chk({7'h00, ch24}, 8'h01);
        ccp = 1'b1;
        fw(1);
        chk({7'h00, ch24}, 8'h00);
        // Fast RAM write then read back of transmit memory b
        pctl = 3'b010;
        addr = 6'h23;
        din = 8'h96;
        repeat (8) @(negedge clk_in);
        pctl = 3'h7;
        repeat (4) @(negedge clk_in);
        pctl = 3'b001;
        repeat (8) @(negedge clk_in);
        chk(data_out, 8'h96);
        chk({7'h00, doe}, 8'h01);
        pctl = 3'h7;
        din = 8'h3C;
        sub = 1'b0;
        repeat (10) @(negedge clk_in);
        chk({5'h00, mode}, {5'h00, MODE_FAST});
        fw(1);
        chk({5'h00, mode}, {5'h00, MODE_BUS});
        chk({5'h00, pctl_oe}, 8'h07);
        chk({2'h0, addr_oe}, 8'h3F);
        chk({7'h00, pctl_out.cs_n}, 8'h00);
        // Delayed select: 4 bit cells = 8 bit-clock cycles = 64 system clocks
        wait (st === 1'b1);
        wait (st === 1'b0);
        @(negedge clk_in);
        k = 0;
        while (st === 1'b0) begin
            k++;
            @(negedge clk_in);
        end
        chk(8'(k), 8'h40);
        fw(1);
        chk(tpa_tdm_model_inst.cap_a[9], 8'h3C);
        give_verdict();
    end
endmodule
